// File: core/lichg_core.sv
/*
  Charge state machine, safety timers, power-switch control, open-drain indicators
  and APB register file of a single-cell lithium charger.
  Assumes the analog stage delivers comparator results as single bits and a
  thermal current fraction in percent; pins are resolved outside from the enables.
*/
// How it works
// - level indicators driven only while charging
// - indicators are open drain, sink when asserted
// - level pair from 2.8V, 3.6V, 4V comparators
// - input valid sinks between UVLO and OVP
// - OVP: valid high, overvolt low; UVLO: both high
// - above 6.9V input switch off, battery on
// - overvolt indicator sinks while above 6.9V
// - enable high gives normal operation
// - enable low: suspend, system from battery
// - constant current, then constant voltage at termination
// - floating current pin keeps charging disabled
// - cycle starts precondition, fast above 2.85V
// - precondition charges at ten percent
// - precondition timeout enters timeout fault
// - fast charge constant current until termination
// - fast timeout to end, restart after relax
// - top-off ends below 10 or 4 percent
// - top-off timeout to end, recharge at -175mV
// - end of charge: battery high impedance, monitored
// - leaving suspend resets timer, enters precondition
// - precondition timeout is one third normal
// - thermal current reduction stretches timers
// - status pair per state
`include "lichg_defines.svh"

module lichg_core #(
  parameter logic [31:0] NORMAL_TO_RST = `LICHG_NTO_RST,
  parameter logic [31:0] TOTAL_TO_RST = `LICHG_TTO_RST,
  parameter logic [31:0] RELAX_CYC = `LICHG_RELAX_CYC
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog stage
  input wire lichg_pkg::lichg_cmp_type cmp,
  input wire logic [6:0] thermal_pct,
  output logic input_switch_on,
  output logic battery_switch_on,
  output logic [6:0] chg_current_pct,
  output logic cv_mode,
  output logic batt_hiz,
  output logic term_sel_4v1,
  // open-drain indicators
  output lichg_pkg::lichg_ind_type ind_out,
  output lichg_pkg::lichg_ind_type ind_oe_n
);
  import lichg_pkg::*;

  lichg_cmp_type cmp_s1;
  lichg_cmp_type cmp_s;
  lichg_state_type state;
  logic [2:0] ctrl;
  logic [31:0] normal_to;
  logic [31:0] total_to;
  logic [31:0] tmr;
  logic [6:0] frac;
  logic [7:0] frac_sum;
  logic [31:0] relax_cnt;
  logic relax;
  logic enable;
  logic mains;
  logic vin_valid;
  logic run_ok;
  logic charging;
  logic [31:0] pre_lim;
  logic topoff_done;
  logic pre_expired;
  logic next_input_on;
  logic wr;
  logic rd_setup;
  logic mapped;

  // true while the cycle is in one of the charging states
  function automatic logic is_charging(input lichg_state_type s);
    return (s == ST_PRE) || (s == ST_FAST) || (s == ST_TOPOFF);
  endfunction

  assign enable = ctrl[`LICHG_CTRL_EN_BIT];
  assign mains = ctrl[`LICHG_CTRL_MAINS_BIT];
  // valid window between lockout and overvoltage
  assign vin_valid = cmp_s.vin_above_uvlo & ~cmp_s.vin_above_ovp;
  // enable, pin and input all good for normal run
  assign run_ok = enable & ~cmp_s.ccc_floating & vin_valid;
  assign charging = is_charging(state);
  // precondition limit is a third of normal
  assign pre_lim = normal_to / `LICHG_PRE_DIV;
  assign pre_expired = tmr >= pre_lim;
  // end threshold picked by mains flag
  assign topoff_done = mains ? cmp_s.ichg_lt_10pct : cmp_s.ichg_lt_4pct;
  assign frac_sum = {1'b0, frac} + {1'b0, thermal_pct};

  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_s1 <= '0;
      cmp_s <= '0;
    end
    else if (ce)
    begin
      cmp_s1 <= cmp;
      cmp_s <= cmp_s1;
    end
  end

  // apb access decode; zero wait states, read data caught in setup
  assign wr = psel & penable & pwrite & ce;
  assign rd_setup = psel & ~penable & ~pwrite & ce;
  assign mapped = (paddr == `LICHG_CTRL_OFS) || (paddr == `LICHG_NTO_OFS) ||
                  (paddr == `LICHG_TTO_OFS) || (paddr == `LICHG_STAT_OFS);
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `LICHG_CTRL_RST;
      normal_to <= NORMAL_TO_RST;
      total_to <= TOTAL_TO_RST;
    end
    else if (wr)
    begin
      if (paddr == `LICHG_CTRL_OFS)
        ctrl <= pwdata[2:0];
      if (paddr == `LICHG_NTO_OFS)
        normal_to <= pwdata;
      if (paddr == `LICHG_TTO_OFS)
        total_to <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
      prdata <= 32'h0000_0000;
      if (paddr == `LICHG_CTRL_OFS)
        prdata <= {29'h0000_0000, ctrl};
      if (paddr == `LICHG_NTO_OFS)
        prdata <= normal_to;
      if (paddr == `LICHG_TTO_OFS)
        prdata <= total_to;
      if (paddr == `LICHG_STAT_OFS)
        prdata <= {26'h000_0000, cmp_s.vin_above_ovp, charging,
                   state == ST_FAULT, state};
    end
  end

  // timer advances by delivered current fraction, so reduction stretches it
  // timer cleared outside charging, so each cycle starts from zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmr <= 32'h0000_0000;
      frac <= 7'h00;
    end
    else if (ce)
    begin
      if (!charging)
      begin
        tmr <= 32'h0000_0000;
        frac <= 7'h00;
      end
      else if (frac_sum >= {1'b0, `LICHG_PCT_FULL})
      begin
        frac <= 7'(frac_sum - {1'b0, `LICHG_PCT_FULL});
        if (tmr != 32'hFFFF_FFFF)
          tmr <= tmr + 32'h0000_0001;
      end
      else
        frac <= frac_sum[6:0];
    end
  end

  // relax interval counted only in end of charge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      relax_cnt <= 32'h0000_0000;
    else if (ce)
    begin
      if (state == ST_EOC && relax)
        relax_cnt <= relax_cnt + 32'h0000_0001;
      else
        relax_cnt <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_SUSP;
      relax <= 1'b0;
    end
    else if (ce)
    begin
      // enable low or no valid input forces suspend
      // fault also left only through suspend
      if (!run_ok)
        state <= ST_SUSP;
      else
      begin
        unique case (state)
          ST_SUSP:
            state <= ST_PRE;
          ST_PRE:
          begin
            // expiry while low marks a damaged cell
            if (cmp_s.vbat_ge_2v85)
              state <= ST_FAST;
            else if (pre_expired)
              state <= ST_FAULT;
          end
          ST_FAST:
          begin
            // termination voltage hands over to top-off
            if (cmp_s.vbat_ge_term)
              state <= ST_TOPOFF;
            else if (tmr >= normal_to)
            begin
              state <= ST_EOC;
              relax <= 1'b1;
            end
          end
          ST_TOPOFF:
          begin
            if (topoff_done || tmr >= total_to)
            begin
              state <= ST_EOC;
              relax <= 1'b0;
            end
          end
          ST_EOC:
          begin
            // restart on 175mV droop, or after relax
            if (relax ? (relax_cnt >= RELAX_CYC - 32'h0000_0001)
                      : cmp_s.vbat_le_recharge)
              state <= ST_PRE;
          end
          ST_FAULT:
            state <= ST_FAULT;
        endcase
      end
    end
  end

  // overvoltage moves the load to the battery
  // suspend by enable low does the same; floating pin suspend keeps the input switch on
  assign next_input_on = vin_valid & enable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_switch_on <= 1'b0;
      battery_switch_on <= 1'b1;
      chg_current_pct <= `LICHG_PCT_OFF;
      cv_mode <= 1'b0;
      batt_hiz <= 1'b1;
      term_sel_4v1 <= 1'b0;
    end
    else if (ce)
    begin
      input_switch_on <= next_input_on;
      battery_switch_on <= ~next_input_on;
      term_sel_4v1 <= ctrl[`LICHG_CTRL_TERM41_BIT];
      // full current in constant current, then voltage loop
      if (state == ST_PRE)
        chg_current_pct <= `LICHG_PCT_PRE;
      else if (state == ST_FAST || state == ST_TOPOFF)
        chg_current_pct <= `LICHG_PCT_FULL;
      else
        chg_current_pct <= `LICHG_PCT_OFF;
      cv_mode <= state == ST_TOPOFF;
      // no charge path outside charging states
      batt_hiz <= ~charging;
    end
  end

  // open drain, data always low, enable low sinks
  assign ind_out = '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ind_oe_n <= '1;
    else if (ce)
    begin
      // level pair active only while charging
      // hi sinks below 3.6V, lo sinks below 2.8V or 3.6V to 4V
      ind_oe_n.batt_level_hi_n <= ~(charging & ~cmp_s.vbat_ge_3v6);
      ind_oe_n.batt_level_lo_n <= ~(charging & (~cmp_s.vbat_ge_2v8 |
                                  (cmp_s.vbat_ge_3v6 & ~cmp_s.vbat_ge_4v0)));
      // valid floats outside window, overvolt floats elsewhere
      ind_oe_n.input_valid_n <= ~vin_valid;
      ind_oe_n.overvolt_ind_n <= ~cmp_s.vin_above_ovp;
      // a sinks in all charging states, b in precondition only
      ind_oe_n.chg_status_a_n <= ~charging;
      ind_oe_n.chg_status_b_n <= ~(state == ST_PRE);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_pre_fault_entry: assert property (ce && state == ST_PRE && run_ok &&
    !cmp_s.vbat_ge_2v85 && pre_expired |=> state == ST_FAULT)
    else $error("precondition timeout did not fault");
  chk_pre_to_fast: assert property (ce && state == ST_PRE && run_ok &&
    cmp_s.vbat_ge_2v85 |=> state == ST_FAST)
    else $error("precondition did not move to fast charge");
  chk_susp_to_pre: assert property (ce && state == ST_SUSP && run_ok
    |=> state == ST_PRE && tmr == 32'h0000_0000)
    else $error("suspend exit wrong");
  chk_fault_holds: assert property (state == ST_FAULT && run_ok |=>
    state == ST_FAULT)
    else $error("fault left while input good");
  chk_ovp_switches: assert property (ce && cmp_s.vin_above_ovp |=>
    !input_switch_on && battery_switch_on && !ind_oe_n.overvolt_ind_n)
    else $error("overvoltage reaction wrong");
  chk_pre_current: assert property (ce && state == ST_PRE |=>
    chg_current_pct == 7'h0A && !ind_oe_n.chg_status_b_n)
    else $error("precondition current or status wrong");
  chk_topoff_end: assert property (ce && state == ST_TOPOFF && run_ok &&
    (mains ? cmp_s.ichg_lt_10pct : cmp_s.ichg_lt_4pct) |=> state == ST_EOC && !relax)
    else $error("top-off did not end");
  chk_status_idle: assert property (ce && !is_charging(state) |=>
    ind_oe_n.chg_status_a_n && ind_oe_n.chg_status_b_n && batt_hiz)
    else $error("idle status pair wrong");
  chk_level_idle: assert property (ce && !charging |=>
    ind_oe_n.batt_level_hi_n && ind_oe_n.batt_level_lo_n)
    else $error("level indicators active while idle");
  chk_sync_delay: assert property (ce ##1 ce |->
    cmp_s == $past(cmp_s1) && cmp_s1 == $past(cmp, 1))
    else $error("synchroniser stage wrong");
  chk_fast_timeout: assert property (ce && state == ST_FAST && run_ok &&
    !cmp_s.vbat_ge_term && tmr >= normal_to |=> state == ST_EOC && relax)
    else $error("fast charge timeout wrong");

  cov_full_cycle: cover property (state == ST_TOPOFF ##1 state == ST_EOC);
  cov_fault: cover property (state == ST_PRE ##1 state == ST_FAULT);
  cov_relax_restart: cover property (state == ST_EOC && relax ##1 state == ST_PRE);
  cov_ovp: cover property (cmp_s.vin_above_ovp && state == ST_SUSP);
endmodule

// File: core/lichg_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the charger control core.
  Assumes a 100 MHz pclk and a 32-bit APB with 12-bit byte addresses.
*/
`ifndef LICHG_DEFINES_SVH
`define LICHG_DEFINES_SVH

`define LICHG_CTRL_OFS 12'h000
`define LICHG_NTO_OFS 12'h004
`define LICHG_TTO_OFS 12'h008
`define LICHG_STAT_OFS 12'h00C

`define LICHG_CTRL_EN_BIT 0
`define LICHG_CTRL_MAINS_BIT 1
`define LICHG_CTRL_TERM41_BIT 2
`define LICHG_CTRL_RST 3'h3

`define LICHG_STAT_FAULT_BIT 3
`define LICHG_STAT_CHG_BIT 4
`define LICHG_STAT_OVP_BIT 5

`define LICHG_NTO_RST 32'h0100_0000
`define LICHG_TTO_RST 32'h0180_0000
`define LICHG_PRE_DIV 32'h0000_0003

`define LICHG_CLK_KHZ 100000
`define LICHG_RELAX_MS 2
`define LICHG_RELAX_CYC (`LICHG_RELAX_MS * `LICHG_CLK_KHZ)

`define LICHG_PCT_FULL 7'h64
`define LICHG_PCT_PRE 7'h0A
`define LICHG_PCT_OFF 7'h00

`endif

// File: core/lichg_pkg.sv
/*
  Types of the charger control core: states, comparator bundle, indicator bundle.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lichg_pkg;
  typedef enum logic [2:0] {
    ST_SUSP,
    ST_PRE,
    ST_FAST,
    ST_TOPOFF,
    ST_EOC,
    ST_FAULT
  } lichg_state_type;

  typedef struct packed {
    logic vbat_ge_2v8;
    logic vbat_ge_2v85;
    logic vbat_ge_3v6;
    logic vbat_ge_4v0;
    logic vbat_ge_term;
    logic vbat_le_recharge;
    logic vin_above_uvlo;
    logic vin_above_ovp;
    logic ichg_lt_10pct;
    logic ichg_lt_4pct;
    logic ccc_floating;
  } lichg_cmp_type;

  typedef struct packed {
    logic batt_level_hi_n;
    logic batt_level_lo_n;
    logic input_valid_n;
    logic overvolt_ind_n;
    logic chg_status_a_n;
    logic chg_status_b_n;
  } lichg_ind_type;
endpackage

// File: test/lichg_stage_model.sv
/*
  Analog stage beside the charger core: comparator bits from battery and input
  millivolts, and pin levels of the open-drain indicators with pull-ups.
  Assumes the bench changes the analog quantities just after a clock edge.
*/
module lichg_stage_model #(
  // assumed lockout level, no figure given
  parameter int UVLO_MV = 32'h0000_0ED8
) (
  // analog quantities
  input wire logic [15:0] vbat_mv,
  input wire logic [15:0] vin_mv,
  input wire logic [6:0] ichg_pct,
  input wire logic ccc_float,
  input wire logic term_sel_4v1,
  // core side
  output lichg_pkg::lichg_cmp_type cmp,
  input wire lichg_pkg::lichg_ind_type ind_out,
  input wire lichg_pkg::lichg_ind_type ind_oe_n,
  output lichg_pkg::lichg_ind_type pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import lichg_pkg::*;
  logic [15:0] term_mv;
  assign term_mv = term_sel_4v1 ? 16'h1004 : 16'h1068;
  assign cmp.vbat_ge_2v8 = vbat_mv >= 16'h0AF0;
  assign cmp.vbat_ge_2v85 = vbat_mv >= 16'h0B22;
  assign cmp.vbat_ge_3v6 = vbat_mv >= 16'h0E10;
  assign cmp.vbat_ge_4v0 = vbat_mv >= 16'h0FA0;
  assign cmp.vbat_ge_term = vbat_mv >= term_mv;
  assign cmp.vbat_le_recharge = vbat_mv <= term_mv - 16'h00AF;
  assign cmp.vin_above_uvlo = vin_mv > 16'(UVLO_MV);
  assign cmp.vin_above_ovp = vin_mv > 16'h1AF4;
  assign cmp.ichg_lt_10pct = ichg_pct < 7'h0A;
  assign cmp.ichg_lt_4pct = ichg_pct < 7'h04;
  assign cmp.ccc_floating = ccc_float;
  // released pin pulled high
  // a released pin reads the pull-up, a driven one the core's data
  assign pins = ind_oe_n | ind_out;
endmodule

// File: test/lichg_core_bench.sv
/*
  Self-checking bench of the charger core with the analog stage model.
  Assumes an APB master in the bench and short timer parameters.
*/
module lichg_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lichg_pkg::*;
  localparam int UVLO_MV = 32'h0000_0ED8;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] vbat_mv, vin_mv;
  logic [6:0] ichg_pct, thermal_pct, chg_current_pct;
  logic ccc_float, input_switch_on, battery_switch_on, cv_mode, batt_hiz, term_sel_4v1;
  lichg_cmp_type cmp;
  lichg_ind_type ind_out, ind_oe_n, pins;
  int err_count, cmp_count;
  logic [11:0] addr_t [5] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h3FC};
  logic [31:0] rst_t [5] = '{32'h3, 32'h12C, 32'h1C2, 32'h0, 32'h0};
  logic [15:0] pre_t [4] = '{16'h0AEF, 16'h0AF0, 16'h0B21, 16'h09C4};
  logic [15:0] fast_t [7] = '{16'h0B23, 16'h0E0F, 16'h0E10, 16'h0F9F, 16'h0FA0, 16'h1067, 16'h0};

  lichg_core #(.NORMAL_TO_RST(32'h12C), .TOTAL_TO_RST(32'h1C2), .RELAX_CYC(32'h14)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp(cmp), .thermal_pct(thermal_pct),
    .input_switch_on(input_switch_on), .battery_switch_on(battery_switch_on),
    .chg_current_pct(chg_current_pct), .cv_mode(cv_mode), .batt_hiz(batt_hiz),
    .term_sel_4v1(term_sel_4v1), .ind_out(ind_out), .ind_oe_n(ind_oe_n));
  lichg_stage_model #(.UVLO_MV(UVLO_MV)) stage (
    .vbat_mv(vbat_mv), .vin_mv(vin_mv), .ichg_pct(ichg_pct), .ccc_float(ccc_float),
    .term_sel_4v1(term_sel_4v1), .cmp(cmp), .ind_out(ind_out), .ind_oe_n(ind_oe_n),
    .pins(pins));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("counts: mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: register %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: outputs %h expected %h", $time, got, exp);
    end
  endtask

  // pins, input and battery switch, cv, battery release, current percent
  function automatic logic [16:0] exp_out(input lichg_state_type st, input logic en);
    logic chg, valid, ovp;
    logic [1:0] lvl;
    chg = st inside {ST_PRE, ST_FAST, ST_TOPOFF};
    ovp = vin_mv > 16'h1AF4;
    valid = vin_mv > 16'(UVLO_MV) && !ovp;
    lvl = vbat_mv < 16'h0AF0 ? 2'b00 : vbat_mv < 16'h0E10 ? 2'b01 :
          vbat_mv < 16'h0FA0 ? 2'b10 : 2'b11;
    if (!chg)
      lvl = 2'b11;
    return {lvl, !valid, !ovp, !chg, st != ST_PRE, valid && en, !(valid && en),
            st == ST_TOPOFF, !chg, st == ST_PRE ? 7'h0A : chg ? 7'h64 : 7'h00};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a stalled access
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_state(input lichg_state_type st, input logic en);
    int n = 0;
    rd = 32'hFFFF_FFFF;
    while (rd[2:0] !== st && n < 400)
    begin
      apb(1'b0, 12'h00C, 32'h0);
      n++;
    end
    chk_reg({29'h0, rd[2:0]}, {29'h0, st});
    // outputs follow one edge after the state
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk_pin({pins, input_switch_on, battery_switch_on, cv_mode, batt_hiz, chg_current_pct},
            exp_out(st, en));
    // hand back on a rising edge so the next stimulus lands there
    @(posedge pclk);
  endtask

  initial
  begin
    repeat (32'h4E20) @(posedge pclk);
    err_count++;
    final_report();
  end

  initial
  begin
    seed = 32'hACAD;
    err_count = 0;
    cmp_count = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, ccc_float} = '0;
    ce = 1'b1;
    vbat_mv = 16'h09C4;
    vin_mv = 16'h1388;
    ichg_pct = 7'h64;
    thermal_pct = 7'h64;
    pre_t[3] = 16'(xorshift() % 32'hAEF);
    fast_t[6] = 16'h0B23 + 16'(xorshift() % 32'h545);
    repeat (6) @(posedge pclk);
    chk_pin({pins, input_switch_on, battery_switch_on, cv_mode, batt_hiz, chg_current_pct},
            {6'h3F, 4'h5, 7'h00});
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, addr_t[i], 32'h0);
      chk_reg(rd, rst_t[i]);
      chk_reg({31'h0, err}, {31'h0, i > 2});
    end
    check_state(ST_PRE, 1'b1);
    foreach (pre_t[i])
    begin
      vbat_mv <= pre_t[i];
      check_state(ST_PRE, 1'b1);
    end
    foreach (fast_t[i])
    begin
      vbat_mv <= fast_t[i];
      check_state(ST_FAST, 1'b1);
    end
    vbat_mv <= 16'h1068;
    ichg_pct <= 7'h0A + 7'(xorshift() % 32'h5B);
    check_state(ST_TOPOFF, 1'b1);
    ichg_pct <= 7'h07;
    check_state(ST_EOC, 1'b1);
    vbat_mv <= 16'h0FB9;
    check_state(ST_FAST, 1'b1);
    apb(1'b1, 12'h000, 32'hFFFF_FFF9);
    apb(1'b0, 12'h000, 32'h0);
    chk_reg(rd, 32'h1);
    vbat_mv <= 16'h1068;
    repeat (8) @(posedge pclk);
    check_state(ST_TOPOFF, 1'b1);
    ichg_pct <= 7'h03;
    check_state(ST_EOC, 1'b1);
    apb(1'b1, 12'h000, 32'h5);
    ichg_pct <= 7'h32;
    vbat_mv <= 16'h0F3C;
    check_state(ST_FAST, 1'b1);
    vbat_mv <= 16'h1004;
    check_state(ST_TOPOFF, 1'b1);
    chk_reg({31'h0, term_sel_4v1}, 32'h1);
    check_state(ST_EOC, 1'b1);
    vbat_mv <= 16'h0BB8;
    check_state(ST_FAST, 1'b1);
    check_state(ST_EOC, 1'b1);
    check_state(ST_FAST, 1'b1);
    vin_mv <= 16'h1B58;
    check_state(ST_SUSP, 1'b1);
    vin_mv <= 16'h0BB8;
    check_state(ST_SUSP, 1'b1);
    vin_mv <= 16'h1388;
    vbat_mv <= 16'h09C4;
    check_state(ST_PRE, 1'b1);
    apb(1'b1, 12'h000, 32'h2);
    check_state(ST_SUSP, 1'b0);
    apb(1'b1, 12'h004, 32'h1E);
    thermal_pct <= 7'h32;
    apb(1'b1, 12'h000, 32'h3);
    check_state(ST_PRE, 1'b1);
    repeat (8) @(posedge pclk);
    check_state(ST_PRE, 1'b1);
    check_state(ST_FAULT, 1'b1);
    vbat_mv <= 16'h0BB8;
    // an input dropout while frozen must not reach the core
    ce <= 1'b0;
    vin_mv <= 16'h0BB8;
    repeat (4) @(posedge pclk);
    chk_reg({31'h0, pready}, 32'h0);
    vin_mv <= 16'h1388;
    repeat (4) @(posedge pclk);
    ce <= 1'b1;
    check_state(ST_FAULT, 1'b1);
    vbat_mv <= 16'h09C4;
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h000, 32'h3);
    check_state(ST_PRE, 1'b1);
    ccc_float <= 1'b1;
    check_state(ST_SUSP, 1'b1);
    final_report();
  end
endmodule
